// [src/access_pkg.sv]
// constants, encodings and timing shared by the access-code checker
package access_pkg;
    localparam int CHAR_W = 6;
    localparam int CODE_LEN = 3;
    localparam int LEN_W = 2;
    // digits 0..9 are codes 00..09, letters follow, space is the last entry
    localparam logic [CHAR_W-1:0] CHAR_LAST = 6'h24;
    localparam logic [CHAR_W-1:0] SEL_SUPER = 6'h00;
    localparam logic [CHAR_W-1:0] SEL_USER = 6'h01;
    localparam logic [CHAR_W-1:0] FIRST_USER = 6'h01;
    localparam logic [1:0] FAIL_LIMIT = 2'h3;
    localparam logic [LEN_W-1:0] LEN_MAX = 2'h3;
    // level index 0 is the privileged level, 1 the ordinary one
    localparam logic LVL_SUPER = 1'b0;
    localparam logic LVL_USER = 1'b1;
    localparam logic [CHAR_W-1:0] DEF_SUPER_0 = 6'h01;
    localparam logic [CHAR_W-1:0] DEF_SUPER_1 = 6'h02;
    localparam logic [CHAR_W-1:0] DEF_SUPER_2 = 6'h03;
    localparam logic [CHAR_W-1:0] DEF_USER_0 = 6'h07;
    localparam logic [CHAR_W-1:0] DEF_USER_1 = 6'h08;
    localparam logic [CHAR_W-1:0] DEF_USER_2 = 6'h09;
    localparam logic ALPHA_RESET = 1'b0;
    localparam int CLK_HZ = 50000000;
    localparam int LONG_PRESS_MS = 5000;
    localparam int LONG_PRESS_CYC = LONG_PRESS_MS * (CLK_HZ / 1000);
    localparam int REMOTE_SLOTS = 8;
    localparam int REMOTE_ID_W = 16;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_LEVEL = 7'b0000010,
        ST_ENTER = 7'b0000100,
        ST_OPEN  = 7'b0001000,
        ST_WHO   = 7'b0010000,
        ST_NEW1  = 7'b0100000,
        ST_NEW2  = 7'b1000000
    } state_t;
endpackage

// [src/long_press.sv]
// detects a push-button held longer than a set number of cycles
`timescale 1ns/1ns
`default_nettype none
module long_press import access_pkg::*; #(
    parameter int LIMIT = LONG_PRESS_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic btn,
    output logic fire_q
);
    localparam int CW = $clog2(LIMIT + 2);
    localparam logic [CW-1:0] AT_LIMIT = CW'(LIMIT);
    localparam logic [CW-1:0] SAT = CW'(LIMIT + 1);
    logic [CW-1:0] cnt_q;

    // saturating, so one press fires exactly once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!btn) begin
            cnt_q <= '0;
        end else if (cnt_q != SAT) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    // strictly longer than the limit: LIMIT+1 held samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fire_q <= 1'b0;
        end else begin
            fire_q <= btn && (cnt_q == AT_LIMIT);
        end
    end

    property p_short_no_fire;
        @(posedge clk) disable iff (!rst_n) (cnt_q < AT_LIMIT) |=> !fire_q;
    endproperty
    a_short_no_fire: assert property (p_short_no_fire) else $error("reset fired on short press");
endmodule
`default_nettype wire

// [src/remote_table.sv]
// table of registered remote control identifiers
`timescale 1ns/1ns
`default_nettype none
module remote_table import access_pkg::*; #(
    parameter int SLOTS = REMOTE_SLOTS,
    parameter int ID_W = REMOTE_ID_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic learn,
    input wire logic check,
    input wire logic clear_all,
    input wire logic [ID_W-1:0] id,
    output logic known_q,
    output logic full_q
);
    logic [SLOTS-1:0] used_q;
    logic [ID_W-1:0] id_q [SLOTS];
    logic [SLOTS-1:0] hit;
    logic [SLOTS-1:0] first_free;

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_slot
            assign hit[g] = used_q[g] && (id_q[g] == id);
            if (g == 0) begin : g_first
                assign first_free[g] = !used_q[g];
            end else begin : g_rest
                assign first_free[g] = !used_q[g] && (&used_q[g-1:0]);
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    used_q[g] <= 1'b0;
                    id_q[g] <= '0;
                end else if (clear_all) begin
                    used_q[g] <= 1'b0;
                end else if (learn && !(|hit) && first_free[g]) begin
                    used_q[g] <= 1'b1;
                    id_q[g] <= id;
                end
            end
        end
    endgenerate

    // a cleared table answers no to every identifier
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            known_q <= 1'b0;
            full_q <= 1'b0;
        end else begin
            known_q <= check && !clear_all && (|hit);
            full_q <= &used_q;
        end
    end

    property p_cleared;
        @(posedge clk) disable iff (!rst_n) clear_all |=> (used_q == '0) && !known_q;
    endproperty
    a_cleared: assert property (p_cleared) else $error("remotes survived remove-all");
endmodule
`default_nettype wire

// [src/access_code_lockout.sv]
// two-level access-code checker with per-level lockout
`timescale 1ns/1ns
`default_nettype none
module access_code_lockout import access_pkg::*; #(
    parameter int LONG_PRESS_CYCLES = LONG_PRESS_CYC,
    parameter int SLOTS = REMOTE_SLOTS,
    parameter int ID_W = REMOTE_ID_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic key_valid,
    input wire logic [CHAR_W-1:0] key_char,
    input wire logic key_ok,
    input wire logic key_cancel,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_pick,
    input wire logic learn_btn,
    input wire logic cmd_login,
    input wire logic cmd_logout,
    input wire logic cmd_change_own,
    input wire logic cmd_change_user,
    input wire logic cmd_remove_remotes,
    input wire logic cmd_set_login,
    input wire logic login_alpha,
    input wire logic remote_learn,
    input wire logic remote_check,
    input wire logic [ID_W-1:0] remote_id,
    output logic ask_level_q,
    output logic ask_user_q,
    output logic ask_repeat_q,
    output logic user_granted_q,
    output logic super_granted_q,
    output logic user_locked_q,
    output logic super_locked_q,
    output logic alpha_mode_q,
    output logic [CHAR_W-1:0] sel_char_q,
    output logic [LEN_W-1:0] entry_len_q,
    output logic msg_ok_q,
    output logic msg_fail_q,
    output logic msg_codes_init_q,
    output logic remote_known_q,
    output logic remote_full_q
);
    state_t st_q;
    state_t st_d;
    logic [CHAR_W-1:0] code_q [2][CODE_LEN];
    logic [LEN_W-1:0] clen_q [2];
    logic [CHAR_W-1:0] ent_q [CODE_LEN];
    logic [CHAR_W-1:0] first_q [CODE_LEN];
    logic [LEN_W-1:0] flen_q;
    logic [1:0] fail_q [2];
    logic lock_q [2];
    logic tgt_q;
    logic tgt_d;
    logic codes_reset;
    logic remove_pulse_q;
    logic [CHAR_W-1:0] char_in;
    logic char_en;
    logic entering;
    logic good_ev;
    logic bad_ev;
    logic new1_ev;
    logic same_ev;
    logic diff_ev;
    logic refuse_ev;
    logic who_bad_ev;

    function automatic logic codes_match(input logic [LEN_W-1:0] la, input logic [CHAR_W-1:0] a [CODE_LEN],
                                         input logic [LEN_W-1:0] lb, input logic [CHAR_W-1:0] b [CODE_LEN]);
        logic eq;
        eq = (la == lb);
        for (int i = 0; i < CODE_LEN; i++) begin
            if (LEN_W'(i) < la && a[i] != b[i]) begin
                eq = 1'b0;
            end
        end
        return eq;
    endfunction

    long_press #(.LIMIT(LONG_PRESS_CYCLES)) u_press (
        .clk(clk),
        .rst_n(rst_n),
        .btn(learn_btn),
        .fire_q(codes_reset)
    );

    remote_table #(.SLOTS(SLOTS), .ID_W(ID_W)) u_remotes (
        .clk(clk),
        .rst_n(rst_n),
        .learn(remote_learn),
        .check(remote_check),
        .clear_all(remove_pulse_q),
        .id(remote_id),
        .known_q(remote_known_q),
        .full_q(remote_full_q)
    );

    assign entering = (st_q == ST_ENTER) || (st_q == ST_NEW1) || (st_q == ST_NEW2);
    // ok and cancel arrive on their own strobes, never as characters
    always_comb begin
        char_in = alpha_mode_q ? sel_char_q : key_char;
        char_en = entering && (entry_len_q != LEN_MAX)
                  && (alpha_mode_q ? key_pick : (key_valid && key_char <= CHAR_LAST));
    end

    assign good_ev = (st_q == ST_ENTER) && key_ok && (entry_len_q != '0)
                     && codes_match(entry_len_q, ent_q, clen_q[tgt_q], code_q[tgt_q]);
    assign bad_ev = (st_q == ST_ENTER) && key_ok && (entry_len_q != '0) && !good_ev;
    assign new1_ev = (st_q == ST_NEW1) && key_ok && (entry_len_q != '0);
    assign same_ev = (st_q == ST_NEW2) && key_ok && (entry_len_q != '0)
                     && codes_match(entry_len_q, ent_q, flen_q, first_q);
    assign diff_ev = (st_q == ST_NEW2) && key_ok && (entry_len_q != '0) && !same_ev;
    assign refuse_ev = (st_q == ST_LEVEL) && key_valid
                       && ((key_char == SEL_SUPER && lock_q[LVL_SUPER]) || (key_char == SEL_USER && lock_q[LVL_USER]));
    assign who_bad_ev = (st_q == ST_WHO) && key_valid && (key_char != FIRST_USER);

    always_comb begin
        st_d = st_q;
        tgt_d = tgt_q;
        case (st_q)
            ST_IDLE: begin
                if (cmd_login) begin
                    st_d = ST_LEVEL;
                end
            end
            ST_LEVEL: begin
                if (key_cancel || refuse_ev) begin
                    st_d = ST_IDLE;
                end else if (key_valid && key_char == SEL_SUPER) begin
                    st_d = ST_ENTER;
                    tgt_d = LVL_SUPER;
                end else if (key_valid && key_char == SEL_USER) begin
                    st_d = ST_ENTER;
                    tgt_d = LVL_USER;
                end
            end
            ST_ENTER: begin
                if (good_ev) begin
                    st_d = ST_OPEN;
                end else if (bad_ev || (key_cancel && entry_len_q == '0)) begin
                    st_d = ST_IDLE;
                end
            end
            ST_OPEN: begin
                if (cmd_logout) begin
                    st_d = ST_IDLE;
                end else if (cmd_change_own) begin
                    st_d = ST_NEW1;
                end else if (cmd_change_user && super_granted_q) begin
                    st_d = ST_WHO;
                    tgt_d = LVL_USER;
                end
            end
            ST_WHO: begin
                if (key_cancel || who_bad_ev) begin
                    st_d = ST_OPEN;
                    tgt_d = LVL_SUPER;
                end else if (key_valid) begin
                    st_d = ST_NEW1;
                end
            end
            ST_NEW1: begin
                if (new1_ev) begin
                    st_d = ST_NEW2;
                end else if (key_cancel && entry_len_q == '0) begin
                    st_d = ST_OPEN;
                    tgt_d = super_granted_q ? LVL_SUPER : LVL_USER;
                end
            end
            ST_NEW2: begin
                if (same_ev || diff_ev || (key_cancel && entry_len_q == '0)) begin
                    st_d = ST_OPEN;
                    tgt_d = super_granted_q ? LVL_SUPER : LVL_USER;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            tgt_q <= LVL_SUPER;
        end else if (codes_reset) begin
            st_q <= ST_IDLE;
            tgt_q <= LVL_SUPER;
        end else begin
            st_q <= st_d;
            tgt_q <= tgt_d;
        end
    end

    // entry buffer; extra characters past three are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            entry_len_q <= '0;
            for (int i = 0; i < CODE_LEN; i++) begin
                ent_q[i] <= '0;
            end
        end else if (!entering || key_ok || codes_reset) begin
            entry_len_q <= '0;
        end else if (key_cancel && entry_len_q != '0) begin
            entry_len_q <= entry_len_q - LEN_W'(1);
        end else if (char_en) begin
            ent_q[entry_len_q] <= char_in;
            entry_len_q <= entry_len_q + LEN_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flen_q <= '0;
            for (int i = 0; i < CODE_LEN; i++) begin
                first_q[i] <= '0;
            end
        end else if (new1_ev) begin
            flen_q <= entry_len_q;
            first_q <= ent_q;
        end
    end

    // stored codes; a mismatched repeat leaves them untouched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_q[LVL_SUPER] <= '{DEF_SUPER_0, DEF_SUPER_1, DEF_SUPER_2};
            code_q[LVL_USER] <= '{DEF_USER_0, DEF_USER_1, DEF_USER_2};
            clen_q[LVL_SUPER] <= LEN_MAX;
            clen_q[LVL_USER] <= LEN_MAX;
        end else if (codes_reset) begin
            code_q[LVL_SUPER] <= '{DEF_SUPER_0, DEF_SUPER_1, DEF_SUPER_2};
            code_q[LVL_USER] <= '{DEF_USER_0, DEF_USER_1, DEF_USER_2};
            clen_q[LVL_SUPER] <= LEN_MAX;
            clen_q[LVL_USER] <= LEN_MAX;
        end else if (same_ev) begin
            code_q[tgt_q] <= ent_q;
            clen_q[tgt_q] <= entry_len_q;
        end
    end

    // one counter and one lock per level
    generate
        for (genvar l = 0; l < 2; l++) begin : g_lvl
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    fail_q[l] <= '0;
                    lock_q[l] <= 1'b0;
                end else if (codes_reset) begin
                    fail_q[l] <= '0;
                    lock_q[l] <= 1'b0;
                end else if (l == 32'(LVL_USER) && same_ev && tgt_q == LVL_USER && super_granted_q) begin
                    fail_q[l] <= '0;
                    lock_q[l] <= 1'b0;
                end else if (good_ev && tgt_q == 1'(l)) begin
                    fail_q[l] <= '0;
                end else if (bad_ev && tgt_q == 1'(l)) begin
                    fail_q[l] <= fail_q[l] + 2'h1;
                    lock_q[l] <= (fail_q[l] + 2'h1 == FAIL_LIMIT);
                end
            end
        end
    endgenerate
    assign super_locked_q = lock_q[LVL_SUPER];
    assign user_locked_q = lock_q[LVL_USER];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            super_granted_q <= 1'b0;
            user_granted_q <= 1'b0;
        end else if (codes_reset || st_d == ST_IDLE) begin
            super_granted_q <= 1'b0;
            user_granted_q <= 1'b0;
        end else if (good_ev) begin
            super_granted_q <= (tgt_q == LVL_SUPER);
            user_granted_q <= (tgt_q == LVL_USER);
        end
    end

    // entry style is a setting, so only the privileged level changes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alpha_mode_q <= ALPHA_RESET;
            sel_char_q <= '0;
        end else begin
            if (cmd_set_login && super_granted_q && st_q == ST_OPEN) begin
                alpha_mode_q <= login_alpha;
            end
            if (alpha_mode_q && key_up) begin
                sel_char_q <= (sel_char_q == CHAR_LAST) ? '0 : sel_char_q + CHAR_W'(1);
            end else if (alpha_mode_q && key_down) begin
                sel_char_q <= (sel_char_q == '0) ? CHAR_LAST : sel_char_q - CHAR_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remove_pulse_q <= 1'b0;
        end else begin
            remove_pulse_q <= cmd_remove_remotes && super_granted_q && st_q == ST_OPEN;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_ok_q <= 1'b0;
            msg_fail_q <= 1'b0;
            msg_codes_init_q <= 1'b0;
            ask_level_q <= 1'b0;
            ask_user_q <= 1'b0;
            ask_repeat_q <= 1'b0;
        end else begin
            msg_ok_q <= same_ev && !codes_reset;
            msg_fail_q <= (diff_ev || bad_ev || refuse_ev || who_bad_ev) && !codes_reset;
            msg_codes_init_q <= codes_reset;
            ask_level_q <= !codes_reset && st_d == ST_LEVEL;
            ask_user_q <= !codes_reset && st_d == ST_WHO;
            ask_repeat_q <= !codes_reset && st_d == ST_NEW2;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_third_miss(int l);
        bad_ev && !codes_reset && tgt_q == l[0] && fail_q[l] == 2'h2;
    endsequence
    property p_lock_third(int l);
        s_third_miss(l) |=> lock_q[l] && msg_fail_q;
    endproperty
    a_lock_third: assert property (p_lock_third(0)) else $error("third miss did not lock");
    property p_lock_third_user;
        s_third_miss(1) |=> lock_q[1] && $stable(lock_q[0]) ##0 $stable(fail_q[0]);
    endproperty
    a_lock_third_user: assert property (p_lock_third_user) else $error("locks not independent");
    property p_refuse;
        refuse_ev && !codes_reset |=> st_q == ST_IDLE && msg_fail_q ##1 st_q == ST_IDLE || st_q == ST_LEVEL;
    endproperty
    a_refuse: assert property (p_refuse) else $error("locked level accepted");
    property p_super_lock_holds;
        lock_q[LVL_SUPER] && !codes_reset |=> lock_q[LVL_SUPER];
    endproperty
    a_super_lock_holds: assert property (p_super_lock_holds) else $error("privileged lock released");
    property p_count_clear;
        fail_q[0] != 2'h0 && !codes_reset && !(good_ev && tgt_q == LVL_SUPER) |=> fail_q[0] != 2'h0;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("failure count cleared");
    sequence s_long_press;
        codes_reset;
    endsequence
    property p_reset_codes;
        s_long_press |=> msg_codes_init_q && clen_q[LVL_USER] == LEN_MAX && code_q[LVL_USER][0] == DEF_USER_0
                         && !super_locked_q && !user_locked_q && st_q == ST_IDLE;
    endproperty
    a_reset_codes: assert property (p_reset_codes) else $error("long press did not restore");
    property p_ok_after_repeat;
        msg_ok_q |-> $past(st_q) == ST_NEW2 ##0 $past(entry_len_q) == clen_q[$past(tgt_q)];
    endproperty
    a_ok_after_repeat: assert property (p_ok_after_repeat) else $error("success without repeat");
    property p_mismatch_keeps;
        diff_ev && !codes_reset |=> $stable(clen_q[0]) && $stable(clen_q[1]) && msg_fail_q && !msg_ok_q;
    endproperty
    a_mismatch_keeps: assert property (p_mismatch_keeps) else $error("mismatch changed code");
    property p_level_first;
        st_q == ST_ENTER && $past(st_q) != ST_ENTER |-> $past(st_q) == ST_LEVEL;
    endproperty
    a_level_first: assert property (p_level_first) else $error("code asked before level");
    property p_entry_bound;
        entry_len_q == LEN_MAX && !key_cancel |=> entry_len_q == LEN_MAX || entry_len_q == '0;
    endproperty
    a_entry_bound: assert property (p_entry_bound) else $error("code longer than three");
endmodule
`default_nettype wire

// [tb/keypad_model.sv]
// keypad partner: one-cycle key strobes
`timescale 1ns/1ns
`default_nettype none
module keypad_model import access_pkg::*; (
    input wire logic clk,
    output logic key_valid,
    output logic [CHAR_W-1:0] key_char,
    output logic key_ok,
    output logic key_cancel
);
    initial begin
        key_valid = 1'b0;
        key_char = 6'h3F;
        key_ok = 1'b0;
        key_cancel = 1'b0;
    end
    // only character keys carry a code, ok is a strobe of its own
    task automatic press(input logic [CHAR_W-1:0] c);
        @(posedge clk);
        key_valid <= 1'b1;
        key_char <= c;
        @(posedge clk);
        key_valid <= 1'b0;
        // released code lines show the inverse, not a stale match
        key_char <= ~c;
    endtask
    task automatic cancel();
        @(posedge clk);
        key_cancel <= 1'b1;
        @(posedge clk);
        key_cancel <= 1'b0;
    endtask
    task automatic accept();
        @(posedge clk);
        key_ok <= 1'b1;
        @(posedge clk);
        key_ok <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb/access_code_lockout_test.sv]
// self-checking bench for the access-code checker
`timescale 1ns/1ns
`default_nettype none
module access_code_lockout_test;
    import access_pkg::*;
    localparam int LP = 20;
    localparam int E_FAIL = 1, E_OK = 2, E_SUP = 3, E_USR = 4, E_INIT = 5, E_KNOWN = 6;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic learn_btn = 1'b0;
    logic login_alpha = 1'b0;
    logic [10:0] cmds = 11'h000;
    logic [15:0] remote_id = 16'h0000;
    logic key_valid, key_ok, key_cancel;
    logic [CHAR_W-1:0] key_char;
    logic user_granted_q, super_granted_q, user_locked_q, super_locked_q, alpha_mode_q;
    logic msg_ok_q, msg_fail_q, msg_codes_init_q, remote_known_q, sup_p, usr_p;
    logic ask_level_q, ask_user_q, ask_repeat_q;
    logic [CHAR_W-1:0] sel_char_q;
    logic [LEN_W-1:0] entry_len_q;
    int q[$];
    int fails = 0, checked = 0, cyc = 0, seed = 32'h260c;
    keypad_model keypad_model_inst (.clk(clk), .key_valid(key_valid), .key_char(key_char),
        .key_ok(key_ok), .key_cancel(key_cancel));
    access_code_lockout #(.LONG_PRESS_CYCLES(LP)) access_code_lockout_inst (.clk(clk), .rst_n(rst_n),
        .key_valid(key_valid), .key_char(key_char), .key_ok(key_ok), .key_cancel(key_cancel),
        .key_up(cmds[8]), .key_down(cmds[9]), .key_pick(cmds[10]), .learn_btn(learn_btn),
        .cmd_login(cmds[0]), .cmd_logout(cmds[1]), .cmd_change_own(cmds[2]),
        .cmd_change_user(cmds[3]), .cmd_remove_remotes(cmds[4]), .cmd_set_login(cmds[5]),
        .login_alpha(login_alpha), .remote_learn(cmds[6]), .remote_check(cmds[7]), .remote_id(remote_id),
        .ask_level_q(ask_level_q), .ask_user_q(ask_user_q), .ask_repeat_q(ask_repeat_q),
        .user_granted_q(user_granted_q), .super_granted_q(super_granted_q), .user_locked_q(user_locked_q),
        .super_locked_q(super_locked_q), .alpha_mode_q(alpha_mode_q), .sel_char_q(sel_char_q),
        .entry_len_q(entry_len_q), .msg_ok_q(msg_ok_q), .msg_fail_q(msg_fail_q),
        .msg_codes_init_q(msg_codes_init_q), .remote_known_q(remote_known_q), .remote_full_q());
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic a, input logic e, input string m);
        checked++;
        if (a !== e) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic take(input int e, input string m);
        checked++;
        if (q.size() == 0 || q[0] != e) begin
            fails++;
            $display("wrong value at %0t: unexpected %s", $time, m);
        end
        if (q.size() != 0) void'(q.pop_front());
    endtask
    // results are taken where settled, half a cycle after the edge
    always @(negedge clk) begin
        if (msg_fail_q === 1'b1) take(E_FAIL, "fail message");
        if (msg_ok_q === 1'b1) take(E_OK, "ok message");
        if (msg_codes_init_q === 1'b1) take(E_INIT, "init message");
        if (remote_known_q === 1'b1) take(E_KNOWN, "known remote");
        if (super_granted_q === 1'b1 && !sup_p) take(E_SUP, "privileged grant");
        if (user_granted_q === 1'b1 && !usr_p) take(E_USR, "ordinary grant");
        sup_p = (super_granted_q === 1'b1);
        usr_p = (user_granted_q === 1'b1);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end
    task automatic cmd(input int i);
        @(posedge clk);
        cmds[i] <= 1'b1;
        @(posedge clk);
        cmds[i] <= 1'b0;
    endtask
    task automatic code(input int n, input logic [17:0] cs);
        for (int i = 0; i < n; i++) keypad_model_inst.press(cs[17-6*i -: 6]);
        keypad_model_inst.accept();
    endtask
    task automatic login(input logic [CHAR_W-1:0] lv, input int n, input logic [17:0] cs, input int e);
        q.push_back(e);
        cmd(0);
        @(negedge clk);
        check(ask_level_q, 1'b1, "level prompt");
        keypad_model_inst.press(lv);
        code(n, cs);
        repeat (3) @(posedge clk);
    endtask
    task automatic change(input int w, input int n, input logic [17:0] a, input logic [17:0] b, input int e);
        q.push_back(e);
        cmd(w);
        if (w == 3) begin
            @(negedge clk);
            check(ask_user_q, 1'b1, "user prompt");
            keypad_model_inst.press(FIRST_USER);
        end
        code(n, a);
        @(negedge clk);
        check(ask_repeat_q, 1'b1, "repeat prompt");
        code(n, b);
        repeat (3) @(posedge clk);
    endtask
    initial begin
        logic [17:0] sup, usr, w;
        sup = {DEF_SUPER_0, DEF_SUPER_1, DEF_SUPER_2};
        usr = {DEF_USER_0, DEF_USER_1, DEF_USER_2};
        w = {6'h04, 6'h05, 6'h06};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check(alpha_mode_q, 1'b0, "numeric default");
        login(SEL_SUPER, 3, sup, E_SUP);
        cmd(1);
        login(SEL_USER, 3, w, E_FAIL);
        login(SEL_USER, 3, w, E_FAIL);
        login(SEL_SUPER, 3, sup, E_SUP);
        cmd(1);
        login(SEL_USER, 3, w, E_FAIL);
        check(user_locked_q, 1'b1, "ordinary lock");
        check(super_locked_q, 1'b0, "privileged free");
        login(SEL_USER, 3, usr, E_FAIL);
        login(SEL_SUPER, 3, sup, E_SUP);
        change(3, 2, 18'h04140, 18'h04140, E_OK);
        check(user_locked_q, 1'b0, "ordinary unlock");
        $display("test lockout done");
        remote_id <= 16'h5A3C;
        cmd(6);
        q.push_back(E_KNOWN);
        cmd(7);
        cmd(4);
        cmd(7);
        login_alpha <= 1'b1;
        cmd(5);
        @(negedge clk);
        check(alpha_mode_q, 1'b1, "alpha style");
        cmd(1);
        q.push_back(E_SUP);
        cmd(0);
        keypad_model_inst.press(SEL_SUPER);
        cmd(8);
        cmd(10);
        repeat (2) cmd(8);
        cmd(10);
        keypad_model_inst.cancel();
        @(negedge clk);
        check(entry_len_q == 2'h1 && sel_char_q == 6'h03, 1'b1, "alpha delete");
        cmd(9);
        cmd(10);
        cmd(8);
        cmd(10);
        keypad_model_inst.accept();
        repeat (3) @(posedge clk);
        login_alpha <= 1'b0;
        cmd(5);
        cmd(1);
        login(SEL_USER, 3, 18'h04140, E_FAIL);
        login(SEL_USER, 2, 18'h04140, E_USR);
        change(2, 1, 18'h1C000, 18'h20000, E_FAIL);
        cmd(1);
        login(SEL_USER, 2, 18'h04140, E_USR);
        cmd(1);
        login(SEL_USER, 3, w, E_FAIL);
        login(SEL_USER, 3, w, E_FAIL);
        check(user_locked_q, 1'b0, "count cleared");
        $display("test rewrite done");
        for (int i = 0; i < 3; i++) login(SEL_SUPER, 3, {6'h04 + 6'($unsigned($random(seed)) % 6), 12'h0C3}, E_FAIL);
        check(super_locked_q, 1'b1, "privileged lock");
        login(SEL_SUPER, 3, sup, E_FAIL);
        learn_btn <= 1'b1;
        repeat (LP - 5) @(posedge clk);
        learn_btn <= 1'b0;
        @(negedge clk);
        check(super_locked_q, 1'b1, "short press");
        q.push_back(E_INIT);
        @(posedge clk);
        learn_btn <= 1'b1;
        repeat (LP + 5) @(posedge clk);
        learn_btn <= 1'b0;
        repeat (3) @(posedge clk);
        check(super_locked_q, 1'b0, "codes reset");
        login(SEL_SUPER, 3, sup, E_SUP);
        cmd(1);
        login(SEL_USER, 3, usr, E_USR);
        check(q.size() == 0, 1'b1, "all results seen");
        $display("test reset done");
        finish_test();
    end
endmodule
`default_nettype wire
